//--- hw/sbr_pkg.sv
// shared constants, types and helpers of the serial baud rate generator
package sbr_pkg;
	localparam int unsigned DIV_W = 8;
	localparam int unsigned PRESC_W = 7;
	localparam int unsigned GAP_W = 16;

	// byte addresses of the word-aligned registers
	localparam logic [31:0] OFS_TXCS = 32'h0000_0000;
	localparam logic [31:0] OFS_RXCS = 32'h0000_0004;
	localparam logic [31:0] OFS_DIV = 32'h0000_0008;
	localparam logic [31:0] OFS_STAT = 32'h0000_000c;

	// transmit_control_status fields
	localparam int unsigned TX_CSRC = 7;
	localparam int unsigned TX_TX9 = 6;
	localparam int unsigned TX_TXEN = 5;
	localparam int unsigned TX_SYNC = 4;
	localparam int unsigned TX_HSEL = 2;
	localparam int unsigned TX_TRMT = 1;
	localparam logic [7:0] TX_WMASK = 8'hf5;
	// receive_control_status fields
	localparam int unsigned RX_SPEN = 7;
	localparam logic [7:0] RX_WMASK = 8'hf8;
	localparam logic [7:0] RX_RMASK = 8'h07;
	// status register fields
	localparam int unsigned ST_LEVEL = 0;
	localparam int unsigned ST_CNT_LSB = 8;

	localparam logic [7:0] TXCS_RST = 8'h00;
	localparam logic [7:0] RXCS_RST = 8'h00;
	localparam logic [7:0] DIV_RST = 8'h00;
	localparam logic [2:0] SAMP_RST = 3'h7;

	localparam logic [PRESC_W-1:0] RATIO_ASYNC_LO = 7'h40;
	localparam logic [PRESC_W-1:0] RATIO_ASYNC_HI = 7'h10;
	localparam logic [PRESC_W-1:0] RATIO_SYNC = 7'h04;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {SBR_ASYNC_LO, SBR_ASYNC_HI, SBR_SYNC} sbr_mode_t;
	typedef enum logic [2:0] {SBR_SEL_TXCS, SBR_SEL_RXCS, SBR_SEL_DIV, SBR_SEL_STAT,
		SBR_SEL_NONE} sbr_sel_t;

	function automatic sbr_mode_t sbr_mode(input logic sync, input logic hsel);
		if (sync) begin
			return SBR_SYNC;
		end
		return hsel ? SBR_ASYNC_HI : SBR_ASYNC_LO;
	endfunction : sbr_mode

	function automatic logic [PRESC_W-1:0] sbr_ratio(input sbr_mode_t m);
		case (m)
			SBR_ASYNC_LO: return RATIO_ASYNC_LO;
			SBR_ASYNC_HI: return RATIO_ASYNC_HI;
			SBR_SYNC: return RATIO_SYNC;
			default: return RATIO_ASYNC_LO;
		endcase
	endfunction : sbr_ratio

	function automatic sbr_sel_t sbr_decode(input logic [31:0] addr);
		case (addr)
			OFS_TXCS: return SBR_SEL_TXCS;
			OFS_RXCS: return SBR_SEL_RXCS;
			OFS_DIV: return SBR_SEL_DIV;
			OFS_STAT: return SBR_SEL_STAT;
			default: return SBR_SEL_NONE;
		endcase
	endfunction : sbr_decode
endpackage : sbr_pkg

//--- hw/sbr_baud_timer.sv
// free-running divisor timer producing one tick per divisor+1 clocks
`timescale 1ns/1ps
module sbr_baud_timer #(
	parameter int unsigned WIDTH = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic enable,
	input wire logic clear,
	input wire logic [WIDTH-1:0] divisor,
	output logic tick_ff,
	output logic [WIDTH-1:0] count_ff
);
	import sbr_pkg::*;

	logic at_end;
	logic [GAP_W-1:0] gap_ff;
	logic seen_ff;

	// >= rather than == so a shrunken divisor can never strand the count
	assign at_end = count_ff >= divisor;

	always_ff @(posedge aclk) begin
		if (!aresetn || !enable || clear) begin
			count_ff <= '0;
		end else if (at_end) begin
			count_ff <= '0;
		end else begin
			count_ff <= WIDTH'(count_ff + 1'b1);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tick_ff <= 1'b0;
		end else begin
			tick_ff <= enable && !clear && at_end;
		end
	end

	// helper: clocks since the last tick, only for checking
	always_ff @(posedge aclk) begin
		if (!aresetn || !enable || clear) begin
			gap_ff <= '0;
			seen_ff <= 1'b0;
		end else if (tick_ff) begin
			gap_ff <= '0;
			seen_ff <= 1'b1;
		end else begin
			gap_ff <= GAP_W'(gap_ff + 1'b1);
		end
	end

	property p_tick_period;
		@(posedge aclk) disable iff (!aresetn)
		tick_ff && seen_ff |-> gap_ff == GAP_W'($past(divisor));
	endproperty
	a_tick_period: assert property (p_tick_period)
		else $error("baud tick spacing differs from divisor plus one");

	property p_count_bound;
		@(posedge aclk) disable iff (!aresetn)
		enable && !clear |-> count_ff <= divisor;
	endproperty
	a_count_bound: assert property (p_count_bound)
		else $error("baud timer count exceeds divisor");

	property p_clear_restart;
		@(posedge aclk) disable iff (!aresetn)
		clear |=> count_ff == '0 && !tick_ff;
	endproperty
	a_clear_restart: assert property (p_clear_restart)
		else $error("divisor write did not restart the baud timer");
endmodule : sbr_baud_timer

//--- hw/sbr_majority.sv
// three-sample majority detector for the receive line
`timescale 1ns/1ps
module sbr_majority (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic enable,
	input wire logic sample_en,
	input wire logic din,
	output logic level_ff
);
	import sbr_pkg::*;

	logic [2:0] samples_ff;

	// idle line is high, so samples start high and no false start is seen
	always_ff @(posedge aclk) begin
		if (!aresetn || !enable) begin
			samples_ff <= SAMP_RST;
		end else if (sample_en) begin
			samples_ff <= {samples_ff[1:0], din};
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			level_ff <= 1'b1;
		end else begin
			level_ff <= (samples_ff[0] & samples_ff[1]) | (samples_ff[0] & samples_ff[2])
				| (samples_ff[1] & samples_ff[2]);
		end
	end

	property p_two_high;
		@(posedge aclk) disable iff (!aresetn)
		(samples_ff == 3'h3 || samples_ff == 3'h5 || samples_ff == 3'h6) |=> level_ff;
	endproperty
	a_two_high: assert property (p_two_high)
		else $error("two high samples did not resolve high");

	property p_two_low;
		@(posedge aclk) disable iff (!aresetn)
		(samples_ff == 3'h4 || samples_ff == 3'h2 || samples_ff == 3'h1) |=> !level_ff;
	endproperty
	a_two_low: assert property (p_two_low)
		else $error("two low samples did not resolve low");
endmodule : sbr_majority

//--- hw/sbr_top.sv
// baud rate generator with receive sampling and AXI4-Lite registers
// Functional notes
// - bit timing comes from the device clock, so rate scales with it.
// - receive level is the majority of three samples of the pin.
// - async low speed: rate is clock over 64 times divisor plus one.
// - async high speed: rate is clock over 16 times divisor plus one.
// - sync mode: rate is clock over 4 times divisor plus one.
// - divisor n is the value software last wrote to the divisor register.
// - one free-running 8-bit timer serves async and sync modes.
// - a divisor write clears the timer one clock after the new divisor lands.
// - async tick runs at 16 or 64 times the bit rate.
`timescale 1ns/1ps
module sbr_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic serial_receive_pin,
	input wire logic tsr_empty,
	input wire logic [2:0] rx_status,
	output logic baud_tick,
	output logic bit_tick,
	output logic rx_level,
	output logic [7:0] transmit_control_status,
	output logic [7:0] receive_control_status
);
	import sbr_pkg::*;

	logic aw_held_ff, w_held_ff;
	logic [31:0] awaddr_ff, wdata_ff;
	logic [3:0] wstrb_ff;
	logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
	logic [1:0] bresp_ff, rresp_ff;
	logic [31:0] rdata_ff;
	logic nxt_aw_held, nxt_w_held, do_write;
	sbr_sel_t wsel, rsel;
	logic [31:0] rd_data;
	logic [1:0] rd_resp;
	logic [7:0] tx_ctrl_ff, rx_ctrl_ff, baud_divisor_ff;
	logic div_wr_ff, tx_wr;
	logic spen;
	sbr_mode_t mode;
	logic [PRESC_W-1:0] ratio;
	logic [PRESC_W-1:0] presc_ff;
	logic presc_end;
	logic bit_tick_ff;
	logic timer_tick;
	logic [DIV_W-1:0] timer_count;
	logic rx_meta_ff, rx_sync_ff;
	logic level;
	logic [GAP_W-1:0] bit_gap_ff, bit_period;
	logic bit_seen_ff, restart;

	assign s_axi_awready = awready_ff;
	assign s_axi_wready = wready_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_arready = arready_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rresp = rresp_ff;
	assign s_axi_rdata = rdata_ff;
	assign transmit_control_status = tx_ctrl_ff;
	assign receive_control_status = rx_ctrl_ff;
	assign bit_tick = bit_tick_ff;
	assign baud_tick = timer_tick;
	assign rx_level = level;

	// write path: address and data are caught independently
	assign do_write = aw_held_ff && w_held_ff && !bvalid_ff;
	assign wsel = sbr_decode(awaddr_ff);
	assign tx_wr = do_write && wsel == SBR_SEL_TXCS && wstrb_ff[0];

	always_comb begin
		nxt_aw_held = aw_held_ff;
		nxt_w_held = w_held_ff;
		if (do_write) begin
			nxt_aw_held = 1'b0;
			nxt_w_held = 1'b0;
		end
		if (s_axi_awvalid && awready_ff) begin
			nxt_aw_held = 1'b1;
		end
		if (s_axi_wvalid && wready_ff) begin
			nxt_w_held = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_ff <= 1'b0;
			w_held_ff <= 1'b0;
			awready_ff <= 1'b0;
			wready_ff <= 1'b0;
			awaddr_ff <= '0;
			wdata_ff <= '0;
			wstrb_ff <= '0;
		end else begin
			aw_held_ff <= nxt_aw_held;
			w_held_ff <= nxt_w_held;
			awready_ff <= !nxt_aw_held;
			wready_ff <= !nxt_w_held;
			if (s_axi_awvalid && awready_ff) begin
				awaddr_ff <= s_axi_awaddr;
			end
			if (s_axi_wvalid && wready_ff) begin
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_ff <= 1'b0;
			bresp_ff <= RESP_OKAY;
		end else if (do_write) begin
			bvalid_ff <= 1'b1;
			bresp_ff <= (wsel == SBR_SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
		end else if (s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	// registers; writes take byte lane 0 only, the status word is read-only
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_ctrl_ff <= TXCS_RST;
			rx_ctrl_ff <= RXCS_RST;
			baud_divisor_ff <= DIV_RST;
		end else if (do_write && wstrb_ff[0]) begin
			case (wsel)
				SBR_SEL_TXCS: tx_ctrl_ff <= wdata_ff[7:0] & TX_WMASK;
				SBR_SEL_RXCS: rx_ctrl_ff <= wdata_ff[7:0] & RX_WMASK;
				SBR_SEL_DIV: baud_divisor_ff <= wdata_ff[7:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_wr_ff <= 1'b0;
		end else begin
			div_wr_ff <= do_write && wstrb_ff[0] && wsel == SBR_SEL_DIV;
		end
	end

	// read path
	assign rsel = sbr_decode(s_axi_araddr);

	always_comb begin
		rd_data = '0;
		rd_resp = RESP_OKAY;
		case (rsel)
			SBR_SEL_TXCS: begin
				rd_data[7:0] = tx_ctrl_ff;
				rd_data[TX_TRMT] = tsr_empty;
			end
			SBR_SEL_RXCS: rd_data[7:0] = rx_ctrl_ff | ({5'h00, rx_status} & RX_RMASK);
			SBR_SEL_DIV: rd_data[7:0] = baud_divisor_ff;
			SBR_SEL_STAT: begin
				rd_data[ST_LEVEL] = level;
				rd_data[ST_CNT_LSB +: DIV_W] = timer_count;
			end
			default: rd_resp = RESP_SLVERR;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b0;
			rdata_ff <= '0;
			rresp_ff <= RESP_OKAY;
		end else if (s_axi_arvalid && arready_ff) begin
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b1;
			rdata_ff <= rd_data;
			rresp_ff <= rd_resp;
		end else if (rvalid_ff && s_axi_rready) begin
			rvalid_ff <= 1'b0;
			arready_ff <= 1'b1;
		end else if (!rvalid_ff) begin
			arready_ff <= 1'b1;
		end
	end

	// baud generation; port enable off holds everything in reset
	assign spen = rx_ctrl_ff[RX_SPEN];
	assign mode = sbr_mode(tx_ctrl_ff[TX_SYNC], tx_ctrl_ff[TX_HSEL]);
	assign ratio = sbr_ratio(mode);

	sbr_baud_timer #(
		.WIDTH(DIV_W)
	) u_baud_timer (
		.aclk(aclk),
		.aresetn(aresetn),
		.enable(spen),
		.clear(div_wr_ff),
		.divisor(baud_divisor_ff),
		.tick_ff(timer_tick),
		.count_ff(timer_count)
	);

	// a mode change mid-count can stretch one bit period; the next is exact
	assign presc_end = presc_ff >= PRESC_W'(ratio - 1'b1);

	always_ff @(posedge aclk) begin
		if (!aresetn || !spen || div_wr_ff) begin
			presc_ff <= '0;
		end else if (timer_tick) begin
			presc_ff <= presc_end ? '0 : PRESC_W'(presc_ff + 1'b1);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bit_tick_ff <= 1'b0;
		end else begin
			bit_tick_ff <= spen && !div_wr_ff && timer_tick && presc_end;
		end
	end

	// receive pin crosses in through two flops before the vote
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_meta_ff <= 1'b1;
			rx_sync_ff <= 1'b1;
		end else begin
			rx_meta_ff <= serial_receive_pin;
			rx_sync_ff <= rx_meta_ff;
		end
	end

	sbr_majority u_majority (
		.aclk(aclk),
		.aresetn(aresetn),
		.enable(spen),
		.sample_en(timer_tick),
		.din(rx_sync_ff),
		.level_ff(level)
	);

	// helper: clocks between bit ticks, only for checking
	// the divisor lands a cycle before its clear, so the write itself restarts too
	assign restart = !spen || div_wr_ff || tx_wr || (do_write && wstrb_ff[0] && wsel == SBR_SEL_DIV);
	assign bit_period = GAP_W'(GAP_W'(ratio) * GAP_W'({1'b0, baud_divisor_ff} + 9'h001));

	always_ff @(posedge aclk) begin
		if (!aresetn || restart) begin
			bit_gap_ff <= '0;
			bit_seen_ff <= 1'b0;
		end else if (bit_tick_ff) begin
			bit_gap_ff <= '0;
			bit_seen_ff <= 1'b1;
		end else begin
			bit_gap_ff <= GAP_W'(bit_gap_ff + 1'b1);
		end
	end

	property p_rate_async_lo;
		@(posedge aclk) disable iff (!aresetn)
		bit_tick_ff && bit_seen_ff && mode == SBR_ASYNC_LO
			|-> bit_gap_ff == GAP_W'(bit_period - 1'b1);
	endproperty
	a_rate_async_lo: assert property (p_rate_async_lo)
		else $error("low speed bit period is not 64 times divisor plus one");

	property p_rate_async_hi;
		@(posedge aclk) disable iff (!aresetn)
		bit_tick_ff && bit_seen_ff && mode == SBR_ASYNC_HI
			|-> bit_gap_ff == GAP_W'(bit_period - 1'b1);
	endproperty
	a_rate_async_hi: assert property (p_rate_async_hi)
		else $error("high speed bit period is not 16 times divisor plus one");

	property p_rate_sync;
		@(posedge aclk) disable iff (!aresetn)
		bit_tick_ff && bit_seen_ff && tx_ctrl_ff[TX_SYNC]
			|-> bit_gap_ff == GAP_W'({6'h00, baud_divisor_ff, 2'h3});
	endproperty
	a_rate_sync: assert property (p_rate_sync)
		else $error("sync bit period is not 4 times divisor plus one");

	property p_bit_on_tick;
		@(posedge aclk) disable iff (!aresetn)
		bit_tick_ff |-> $past(timer_tick) && (!timer_tick || $past(baud_divisor_ff) == DIV_RST);
	endproperty
	a_bit_on_tick: assert property (p_bit_on_tick)
		else $error("bit tick not aligned to a baud tick");

	property p_clock_derived;
		@(posedge aclk) disable iff (!aresetn)
		timer_tick && baud_divisor_ff != DIV_RST && !div_wr_ff |=> !timer_tick;
	endproperty
	a_clock_derived: assert property (p_clock_derived)
		else $error("baud tick faster than the device clock allows");

	property p_divisor_store;
		@(posedge aclk) disable iff (!aresetn)
		do_write && wstrb_ff[0] && wsel == SBR_SEL_DIV
			|=> baud_divisor_ff == $past(wdata_ff[7:0]) && div_wr_ff;
	endproperty
	a_divisor_store: assert property (p_divisor_store)
		else $error("divisor register does not hold the written value");
endmodule : sbr_top

//--- tb/test_serial_baud_rate_generator.sv
// self-checking testbench of the serial baud rate generator
`timescale 1ns/1ps
module test_serial_baud_rate_generator;
	import sbr_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
	logic [31:0] s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic serial_receive_pin = 1'b1;
	logic tsr_empty = 1'b0;
	logic [2:0] rx_status = 3'h0;
	logic baud_tick, bit_tick, rx_level;
	logic [7:0] txcs, rxcs;
	int err_total = 0;
	int comparisons = 0;
	int cyc = 0;
	int c;
	logic [31:0] mode_w [4] = '{32'h00, 32'h04, 32'h10, 32'h14};
	int ratio [4] = '{64, 16, 4, 4};
	int dv [2] = '{0, 3};

	always #20 aclk = ~aclk;

	sbr_top sbr_top_inst (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.serial_receive_pin(serial_receive_pin),
		.tsr_empty(tsr_empty),
		.rx_status(rx_status),
		.baud_tick(baud_tick),
		.bit_tick(bit_tick),
		.rx_level(rx_level),
		.transmit_control_status(txcs),
		.receive_control_status(rxcs)
	);

	task automatic print_verdict;
		$display("comparisons=%0d mismatches=%0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : print_verdict

	// a hung handshake ends the run here
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			print_verdict();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic end_test(input string name);
		$display("test %s done at %0t", name, $time);
	endtask : end_test

	// leading edge keeps back-to-back calls from driving a signal twice in one step
	task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
			input logic [1:0] er);
		bit aw;
		bit w;
		aw = 1'b0;
		w = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw && w)) begin
			@(posedge aclk);
			if (!aw && s_axi_awready === 1'b1) begin
				aw = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w && s_axi_wready === 1'b1) begin
				w = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		while (s_axi_bvalid !== 1'b1) @(posedge aclk);
		s_axi_bready <= 1'b0;
		chk({30'h0, s_axi_bresp}, {30'h0, er});
	endtask : wr

	task automatic rd_chk(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata, e);
		chk({30'h0, s_axi_rresp}, {30'h0, er});
	endtask : rd_chk

	task automatic wait_tick(input bit b);
		do @(posedge aclk); while ((b ? bit_tick : baud_tick) !== 1'b1);
	endtask : wait_tick

	// first tick after a mode change may come late, so measure the next full period
	task automatic gap(input bit b, input int n);
		int k;
		wait_tick(b);
		k = 0;
		do begin
			@(posedge aclk);
			k++;
		end while ((b ? bit_tick : baud_tick) !== 1'b1);
		chk(32'(k), 32'(n));
	endtask : gap

	task automatic count_high(input int n);
		c = 0;
		repeat (n) begin
			@(posedge aclk);
			c += (rx_level === 1'b1) ? 1 : 0;
		end
	endtask : count_high

	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		rd_chk(OFS_TXCS, 32'h0, RESP_OKAY);
		rd_chk(OFS_RXCS, 32'h0, RESP_OKAY);
		rd_chk(OFS_DIV, 32'h0, RESP_OKAY);
		rd_chk(OFS_STAT, 32'h1, RESP_OKAY);
		rd_chk(32'h10, 32'h0, RESP_SLVERR);
		wr(32'h10, 32'hff, 4'hf, RESP_SLVERR);
		end_test("reset");

		wr(OFS_TXCS, 32'hffff_ffff, 4'hf, RESP_OKAY);
		rd_chk(OFS_TXCS, 32'hf5, RESP_OKAY);
		chk({24'h0, txcs}, 32'hf5);
		tsr_empty <= 1'b1;
		rd_chk(OFS_TXCS, 32'hf7, RESP_OKAY);
		rx_status <= 3'h5;
		wr(OFS_RXCS, 32'h78, 4'hf, RESP_OKAY);
		rd_chk(OFS_RXCS, 32'h7d, RESP_OKAY);
		chk({24'h0, rxcs}, 32'h78);
		wr(OFS_DIV, 32'ha5, 4'hf, RESP_OKAY);
		rd_chk(OFS_DIV, 32'ha5, RESP_OKAY);
		wr(OFS_DIV, 32'h3c, 4'h0, RESP_OKAY);
		rd_chk(OFS_DIV, 32'ha5, RESP_OKAY);
		wr(OFS_STAT, 32'h0, 4'hf, RESP_OKAY);
		end_test("registers");

		// port disabled: the whole baud path is held quiet
		c = 0;
		repeat (40) begin
			@(posedge aclk);
			c += (baud_tick === 1'b1 || bit_tick === 1'b1) ? 1 : 0;
		end
		chk(32'(c), 32'h0);
		end_test("disabled");

		wr(OFS_RXCS, 32'h80, 4'hf, RESP_OKAY);
		for (int k = 0; k < 2; k++) begin
			wr(OFS_DIV, 32'(dv[k]), 4'hf, RESP_OKAY);
			gap(1'b0, dv[k] + 1);
			for (int m = 0; m < 4; m++) begin
				wr(OFS_TXCS, mode_w[m], 4'hf, RESP_OKAY);
				gap(1'b1, ratio[m] * (dv[k] + 1));
			end
		end
		end_test("rates");

		wr(OFS_DIV, 32'd200, 4'hf, RESP_OKAY);
		wait_tick(1'b0);
		repeat (60) @(posedge aclk);
		wr(OFS_DIV, 32'd200, 4'hf, RESP_OKAY);
		c = 0;
		do begin
			@(posedge aclk);
			c++;
		end while (baud_tick !== 1'b1 && c < 400);
		chk({31'h0, c >= 201 && c <= 203}, 32'h1);
		end_test("restart");

		wr(OFS_DIV, 32'h0, 4'hf, RESP_OKAY);
		serial_receive_pin <= 1'b0;
		repeat (10) @(posedge aclk);
		chk({31'h0, rx_level}, 32'h0);
		serial_receive_pin <= 1'b1;
		@(posedge aclk);
		serial_receive_pin <= 1'b0;
		count_high(10);
		chk(32'(c), 32'h0);
		serial_receive_pin <= 1'b1;
		repeat (2) @(posedge aclk);
		serial_receive_pin <= 1'b0;
		count_high(10);
		chk({31'h0, c != 0}, 32'h1);
		serial_receive_pin <= 1'b1;
		wr(OFS_RXCS, 32'h0, 4'hf, RESP_OKAY);
		rd_chk(OFS_STAT, 32'h1, RESP_OKAY);
		end_test("sampling");
		print_verdict();
	end
endmodule : test_serial_baud_rate_generator
